/* File: src/civ_pkg.sv */
/*
  Shared constants and carrier types for the current input value coder.
  Assumes a single 40 MHz clock domain and samples already scaled by the front end.
*/
`default_nettype none

package civ_pkg;

  // ****************************************************************
  // Sizes and register map
  // ****************************************************************
  localparam int          NCH       = 2;
  localparam int          EV_W      = 4;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_CFG0   = 8'h04;
  localparam logic [7:0]  ADDR_CFG1   = 8'h08;
  localparam logic [7:0]  ADDR_VALUE0 = 8'h0C;
  localparam logic [7:0]  ADDR_VALUE1 = 8'h10;
  localparam logic [7:0]  ADDR_STATUS = 8'h14;
  localparam logic [7:0]  ADDR_MASK   = 8'h18;
  localparam logic [7:0]  ADDR_DIAG   = 8'h1C;

  // ****************************************************************
  // Measuring ranges, resolution and event bits
  // ****************************************************************
  localparam logic [1:0]  RANGE_OFF   = 2'h0;
  localparam logic [1:0]  RANGE_4_20  = 2'h1;
  localparam logic [1:0]  RANGE_0_20  = 2'h2;
  localparam logic [1:0]  RANGE_BIP   = 2'h3;
  localparam logic [2:0]  RES_MAX_SEL = 3'h4;
  localparam int          EV_OPEN     = 0;
  localparam int          EV_LOWER    = 1;
  localparam int          EV_UPPER    = 2;
  localparam int          EV_PARAM    = 3;

  // ****************************************************************
  // Codes, limits and scaling
  // ****************************************************************
  localparam logic [15:0]        CODE_OVERFLOW  = 16'h7FFF;
  localparam logic [15:0]        CODE_UNDERFLOW = 16'h8000;
  localparam logic [15:0]        CODE_ZERO      = 16'h0000;
  localparam logic [15:0]        ALIGN_ONES     = 16'hFFFF;
  localparam logic signed [19:0] LIM_OVS        = 20'sh07EFF;
  localparam logic signed [19:0] LIM_UND_4_20   = 20'shFED00;
  localparam logic signed [19:0] LIM_UND_BIP    = 20'shF8100;
  localparam logic signed [19:0] LIM_ZERO       = 20'sh00000;
  // Raw samples count 20 mA as 138240 steps, so 4 mA is 27648 steps.
  localparam logic signed [39:0] RAW_4MA        = 40'sh00_0000_6C00;
  localparam logic signed [39:0] RAW_NO_OFFSET  = 40'sh00_0000_0000;
  localparam logic signed [39:0] SCALE_UNI      = 40'sh00_0000_3333;
  localparam logic signed [39:0] SCALE_4_20     = 40'sh00_0000_4000;
  localparam logic signed [39:0] SCALE_ROUND    = 40'sh00_0000_8000;
  localparam int                 SCALE_SHIFT    = 16;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [2:0] res;
    logic       wb_en;
    logic [1:0] range;
  } civ_cfg_s;

  typedef struct packed {
    logic rv_en;
    logic params_done;
  } civ_ctrl_s;

  typedef struct packed {
    logic              valid;
    logic              ch;
    logic signed [19:0] raw;
  } civ_sample_s;

  typedef struct packed {
    logic        valid;
    logic        ch;
    logic [15:0] data;
  } civ_word_s;

  typedef struct packed {
    logic [15:0]     code;
    logic [EV_W-1:0] ev;
  } civ_enc_s;

  localparam civ_cfg_s  CFG_RESET  = '{res: 3'h4, wb_en: 1'b0, range: 2'h1};
  localparam civ_ctrl_s CTRL_RESET = '{rv_en: 1'b0, params_done: 1'b0};

endpackage : civ_pkg

`default_nettype wire

/* File: src/civ_coder.sv */
/*
  Current input value coder: turns raw current samples into 16-bit process words,
  with per-channel range, resolution and wire-break settings over Avalon-MM.
  Assumes samples come from logic on ref_clk and that the host follows Avalon waitrequest.
*/
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: Every measurement leaves as a 16-bit two's-complement word in one common format.
// R02: Bit 15 is the sign, zero positive and one negative, and bits 14 to 0 weigh 2^14 to 2^0.
// R03: A result of fewer than fifteen bits plus sign is left aligned and its unused low bits are zero.
// R04: The lowest valid bit weighs 16, 8, 4, 2 or 1 for 11, 12, 13, 14 or 15 bits plus sign.
// R05: In the unipolar ranges the lower limit codes as 0 and 20 mA as 27648, linear between.
// R06: Above nominal the unipolar codes run 27649 to 32511, and beyond that overflow reads 32767.
// R07: In 4-20 mA underrange runs -1 to -4864, and below 1.185 mA underflow and wire break are detected.
// R08: In the bipolar range 20 mA maps to 27648 either way, with 32511/-32512 bands and 32767/-32768 beyond.
// R09: With wire-break checking on in 4-20 mA, an open loop reads 32767 and raises an open-circuit event.
// R10: With wire-break checking off and range checking on, an open loop reads 8000 hex and raises a low-limit event.
// R11: With both checks off, an open loop reads 8000 hex and raises no event.
// R12: Before parameters are set, or while they are faulty, the channel reads 7FFF hex.
// R13: Each channel is coded on its own with its own range and wire-break enable; the range-check enable rv_en is shared.
module civ_coder (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Raw samples from the converter
  input  wire civ_pkg::civ_sample_s sample,
  // Process words toward the host
  output var  civ_pkg::civ_word_s   host_accumulator,
  output logic                      irq,
  // Avalon-MM slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);

  localparam int SW = civ_pkg::NCH * civ_pkg::EV_W;

  // ****************************************************************
  // Encoding
  // ****************************************************************
  function automatic civ_pkg::civ_enc_s encode(input logic signed [19:0] raw,
                                               input civ_pkg::civ_cfg_s  cfg,
                                               input logic               rv_en);
    civ_pkg::civ_enc_s        e;
    logic signed [39:0]       diff;
    logic signed [39:0]       prod;
    logic signed [19:0]       scaled;
    logic                     fault;
    logic [15:0]              mask;
    e.code = civ_pkg::CODE_OVERFLOW;
    e.ev   = '0;
    fault  = (cfg.res > civ_pkg::RES_MAX_SEL) ||
             (cfg.wb_en && (cfg.range != civ_pkg::RANGE_4_20));
    mask   = civ_pkg::ALIGN_ONES << (civ_pkg::RES_MAX_SEL - cfg.res);   // [R03] [R04]
    diff   = 40'(raw) - ((cfg.range == civ_pkg::RANGE_4_20) ? civ_pkg::RAW_4MA : civ_pkg::RAW_NO_OFFSET);
    // Rounded fixed-point multiply keeps 20 mA exactly on 27648 in every range.
    prod   = diff * ((cfg.range == civ_pkg::RANGE_4_20) ? civ_pkg::SCALE_4_20 : civ_pkg::SCALE_UNI)
             + civ_pkg::SCALE_ROUND;                                    // [R05] [R08]
    scaled = prod[civ_pkg::SCALE_SHIFT +: 20];
    if (cfg.range == civ_pkg::RANGE_OFF) begin
      e.code = civ_pkg::CODE_OVERFLOW;                                  // [R12]
    end else if (fault) begin
      e.code = civ_pkg::CODE_OVERFLOW;                                  // [R12]
      e.ev[civ_pkg::EV_PARAM] = 1'b1;
    end else if (scaled > civ_pkg::LIM_OVS) begin
      e.code = civ_pkg::CODE_OVERFLOW;                                  // [R06] [R08]
      e.ev[civ_pkg::EV_UPPER] = rv_en;
    end else if ((cfg.range == civ_pkg::RANGE_4_20) && (scaled < civ_pkg::LIM_UND_4_20)) begin
      if (cfg.wb_en) begin
        e.code = civ_pkg::CODE_OVERFLOW;                                // [R07] [R09]
        e.ev[civ_pkg::EV_OPEN] = 1'b1;
      end else begin
        e.code = civ_pkg::CODE_UNDERFLOW;                               // [R07] [R10] [R11]
        e.ev[civ_pkg::EV_LOWER] = rv_en;
      end
    end else if ((cfg.range == civ_pkg::RANGE_BIP) && (scaled < civ_pkg::LIM_UND_BIP)) begin
      e.code = civ_pkg::CODE_UNDERFLOW;                                 // [R08]
      e.ev[civ_pkg::EV_LOWER] = rv_en;
    end else if ((cfg.range == civ_pkg::RANGE_0_20) && (scaled < civ_pkg::LIM_ZERO)) begin
      // Negative values do not exist in 0-20 mA, so noise below zero pins to the lower limit.
      e.code = civ_pkg::CODE_ZERO;                                      // [R05]
    end else begin
      e.code = scaled[15:0] & mask;                                     // [R01] [R02] [R03]
    end
    return e;
  endfunction : encode

  // ****************************************************************
  // State
  // ****************************************************************
  civ_pkg::civ_ctrl_s   ctrl;
  civ_pkg::civ_ctrl_s   next_ctrl;
  civ_pkg::civ_cfg_s    cfg        [civ_pkg::NCH];
  civ_pkg::civ_cfg_s    next_cfg   [civ_pkg::NCH];
  logic [15:0]          value      [civ_pkg::NCH];
  logic [15:0]          next_value [civ_pkg::NCH];
  logic [SW-1:0]        diag;
  logic [SW-1:0]        next_diag;
  logic [SW-1:0]        irq_status;
  logic [SW-1:0]        next_irq_status;
  logic [SW-1:0]        irq_mask;
  logic [SW-1:0]        next_irq_mask;
  logic                 ack;
  logic                 next_ack;
  logic [31:0]          next_readdata;
  civ_pkg::civ_word_s   next_host_accumulator;
  civ_pkg::civ_enc_s    enc;
  logic [SW-1:0]        set_bits;
  logic                 wr_go;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_ctrl             = ctrl;
    next_cfg              = cfg;
    next_value            = value;
    next_diag             = diag;
    next_irq_mask         = irq_mask;
    next_irq_status       = irq_status;
    next_readdata         = avs_readdata;
    next_host_accumulator = host_accumulator;
    next_host_accumulator.valid = 1'b0;
    set_bits              = '0;
    enc                   = encode(sample.raw, cfg[sample.ch], ctrl.rv_en);   // [R13]
    // One wait cycle per access: the read word is latched in the first cycle.
    next_ack = (avs_read || avs_write) && !ack;
    wr_go    = avs_write && ack && avs_byteenable[0];

    if (avs_read && !ack) begin
      unique case (avs_address)
        civ_pkg::ADDR_CTRL:   next_readdata = 32'(ctrl);
        civ_pkg::ADDR_CFG0:   next_readdata = 32'(cfg[0]);
        civ_pkg::ADDR_CFG1:   next_readdata = 32'(cfg[1]);
        civ_pkg::ADDR_VALUE0: next_readdata = 32'(value[0]);
        civ_pkg::ADDR_VALUE1: next_readdata = 32'(value[1]);
        civ_pkg::ADDR_STATUS: next_readdata = 32'(irq_status);
        civ_pkg::ADDR_MASK:   next_readdata = 32'(irq_mask);
        civ_pkg::ADDR_DIAG:   next_readdata = 32'(diag);
        default:              next_readdata = 32'h0000_0000;
      endcase
    end

    if (sample.valid) begin
      if (ctrl.params_done) begin
        next_value[sample.ch] = enc.code;                               // [R13]
        next_diag[sample.ch*civ_pkg::EV_W +: civ_pkg::EV_W] = enc.ev;
        set_bits[sample.ch*civ_pkg::EV_W +: civ_pkg::EV_W]  = enc.ev;
        next_host_accumulator = '{valid: 1'b1, ch: sample.ch, data: enc.code};
      end else begin
        next_host_accumulator = '{valid: 1'b1, ch: sample.ch, data: civ_pkg::CODE_OVERFLOW};   // [R12]
      end
    end

    // A parameter write wins over a sample in the same cycle and restarts the channel at 7FFF.
    if (wr_go) begin
      unique case (avs_address)
        civ_pkg::ADDR_CTRL: begin
          next_ctrl = civ_pkg::civ_ctrl_s'(avs_writedata[1:0]);
          for (int c = 0; c < civ_pkg::NCH; c++) begin
            next_value[c] = civ_pkg::CODE_OVERFLOW;                     // [R12]
          end
        end
        civ_pkg::ADDR_CFG0: begin
          next_cfg[0]   = civ_pkg::civ_cfg_s'(avs_writedata[5:0]);
          next_value[0] = civ_pkg::CODE_OVERFLOW;                       // [R12] [R13]
        end
        civ_pkg::ADDR_CFG1: begin
          next_cfg[1]   = civ_pkg::civ_cfg_s'(avs_writedata[5:0]);
          next_value[1] = civ_pkg::CODE_OVERFLOW;                       // [R12] [R13]
        end
        civ_pkg::ADDR_STATUS: next_irq_status = irq_status & ~avs_writedata[SW-1:0];
        civ_pkg::ADDR_MASK:   next_irq_mask   = avs_writedata[SW-1:0];
        default: ;
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    next_irq_status = next_irq_status | set_bits;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl             <= civ_pkg::CTRL_RESET;
      for (int c = 0; c < civ_pkg::NCH; c++) begin
        cfg[c]   <= civ_pkg::CFG_RESET;
        value[c] <= civ_pkg::CODE_OVERFLOW;
      end
      diag             <= '0;
      irq_status       <= '0;
      irq_mask         <= '0;
      ack              <= 1'b0;
      avs_readdata     <= 32'h0000_0000;
      host_accumulator <= '0;
    end else begin
      ctrl             <= next_ctrl;
      cfg              <= next_cfg;
      value            <= next_value;
      diag             <= next_diag;
      irq_status       <= next_irq_status;
      irq_mask         <= next_irq_mask;
      ack              <= next_ack;
      avs_readdata     <= next_readdata;
      host_accumulator <= next_host_accumulator;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign irq             = |(irq_status & irq_mask);

endmodule : civ_coder

`default_nettype wire

/* File: verification/civ_checker.sv */
/* Concurrent checks on the coder's ports.
   Assumes it is bound to civ_coder, one clock, srst synchronous and active high. */
`timescale 1ns/1ps
`default_nettype none
module civ_checker (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 srst,
  // Streams
  input wire civ_pkg::civ_sample_s sample,
  input wire civ_pkg::civ_word_s   host_accumulator,
  input wire logic                 irq,
  // Avalon-MM slave
  input wire logic [7:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic              req = avs_read | avs_write;
  wire logic signed [15:0] w  = host_accumulator.data;
  a_word_timing: assert property (host_accumulator.valid == $past(sample.valid)) else $error("word strobe misplaced");
  a_word_chan: assert property (sample.valid |=> host_accumulator.ch == $past(sample.ch)) else $error("word channel wrong");
  a_word_stands: assert property ($changed(host_accumulator.data) |-> $past(sample.valid)) else $error("word moved");
  a_ovf_gap: assert property (host_accumulator.valid && w > 16'sd32511 |-> w == 16'sh7FFF) else $error("overflow code");
  a_unf_gap: assert property (host_accumulator.valid && w < -16'sd32512 |-> w == 16'sh8000) else $error("underflow code");
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait state");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait state too long");
  a_wait_idle: assert property (!req |-> !avs_waitrequest) else $error("waitrequest while idle");
  a_rdata_stands: assert property ($changed(avs_readdata) |-> $past(avs_read)) else $error("readdata moved");
  a_irq_cause: assert property ($changed(irq) |-> $past(avs_write | sample.valid)) else $error("irq moved alone");
  c_overflow: cover property (host_accumulator.valid && host_accumulator.data == 16'h7FFF);
  c_underflow: cover property (host_accumulator.valid && host_accumulator.data == 16'h8000);
  c_irq: cover property ($rose(irq));
endmodule : civ_checker
`default_nettype wire

/* File: verification/civ_host_model.sv */
/* Host controller model that takes every process word from the coder.
   Assumes the coder's word strobe is a one-cycle pulse on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module civ_host_model (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Process words
  input  wire civ_pkg::civ_word_s   host_accumulator,
  output var  int                   n_words
);
  // A host only counts words here; the bench compares the total with what it sent.
  always_ff @(posedge ref_clk) begin
    if (srst) n_words <= 0;
    else if (host_accumulator.valid === 1'b1) n_words <= n_words + 1;
  end
endmodule : civ_host_model
`default_nettype wire

/* File: verification/current_input_value_coder_tb.sv */
/* Self-checking bench for civ_coder: Avalon host tasks, corner and random samples.
   Assumes the checker and host model are compiled beforehand. */
`timescale 1ns/1ps
`default_nettype none
module current_input_value_coder_tb;
  logic                 ref_clk = 1'b0;
  logic                 srst = 1'b1;
  civ_pkg::civ_sample_s sample = '0;
  civ_pkg::civ_word_s   host_accumulator;
  logic                 irq, avs_waitrequest, rv, c;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [7:0]           avs_address = 8'h00;
  logic [7:0]           st;
  logic [31:0]          avs_writedata = 32'h0;
  logic [31:0]          avs_readdata, q;
  logic [3:0]           avs_byteenable = 4'hF;
  logic [5:0]           cfg [2];
  logic [19:0]          e;
  int                   fails = 0, n_checks = 0, n_words, raw;
  int                   corner [7] = '{138240, 27648, 0, 8190, -138240, 163000, 27647};
  always #12.5 ref_clk = ~ref_clk;
  civ_coder dut (.ref_clk(ref_clk), .srst(srst), .sample(sample), .host_accumulator(host_accumulator), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  civ_host_model u_host (.ref_clk(ref_clk), .srst(srst), .host_accumulator(host_accumulator), .n_words(n_words));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test;
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // The request is held until the rising edge that sees waitrequest low; read data is taken at that edge.
  // One idle edge follows, so a back-to-back call never lowers and raises a strobe in one time step.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 40) begin
        fails++;
        stop_test();
      end
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd
  task automatic send(input logic ch, input int r, input logic [15:0] exp);
    sample <= '{valid: 1'b1, ch: ch, raw: r[19:0]};
    @(posedge ref_clk);
    sample.valid <= 1'b0;
    @(negedge ref_clk);
    check({14'h0, host_accumulator}, {14'h0, 1'b1, ch, exp});
    @(posedge ref_clk);
  endtask : send
  // Expected {events, code} for one sample under a channel setting.
  function automatic logic [19:0] exp_of(input logic [5:0] k, input logic r, input int x);
    longint      v;
    logic [15:0] w;
    logic [3:0]  ev;
    ev = 4'h0;
    w = 16'h7FFF;
    v = (k[1:0] == 2'h1) ? ((longint'(x) - 27648) * 16384 + 32768) >>> 16 : (longint'(x) * 13107 + 32768) >>> 16;
    if (k[1:0] == 2'h0) ev = 4'h0;
    else if (k[5:3] > 3'h4 || (k[2] && k[1:0] != 2'h1)) ev[3] = 1'b1;
    else if (v > 32511) ev[2] = r;
    else if (k[1:0] == 2'h1 && v < -4864 && k[2]) ev[0] = 1'b1;
    else if ((k[1:0] == 2'h1 && v < -4864) || (k[1:0] == 2'h3 && v < -32512)) begin
      w = 16'h8000;
      ev[1] = r;
    end
    else w = (k[1:0] == 2'h2 && v < 0) ? 16'h0 : 16'(v) & (16'hFFFF << (3'h4 - k[5:3]));
    return {ev, w};
  endfunction : exp_of
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    void'($urandom(32'hb9405874));
    @(posedge ref_clk);
    rd(8'h04, 32'h21);
    rd(8'h10, 32'h7FFF);
    rd(8'h40, 32'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, 8'h00, 32'h3);
    avs_byteenable <= 4'hF;
    send(1'b0, 138240, 16'h7FFF);
    rd(8'h14, 32'h0);
    cfg[0] = 6'h21;
    cfg[1] = 6'h21;
    st = 8'h00;
    rv = 1'b0;
    for (int i = 0; i < 150; i++) begin
      c = 1'($urandom_range(0, 1));
      if (i % 25 == 0) begin
        rv = (i == 0) ? 1'b1 : 1'($urandom_range(0, 1));
        bus(1'b1, 8'h00, {30'h0, rv, 1'b1});
      end
      if (i >= 7) begin
        cfg[c] = (i < 14) ? 6'h25 : (i < 21) ? 6'h23 : 6'($urandom_range(0, 63));
        bus(1'b1, 8'h04 + {5'h0, c, 2'h0}, {26'h0, cfg[c]});
      end
      raw = (i < 21) ? corner[i % 7] : int'($urandom_range(0, 330000)) - 165000;
      e = exp_of(cfg[c], rv, raw);
      send(c, raw, e[15:0]);
      st = st | (8'(e[19:16]) << (4 * c));
      rd(8'h0C + {5'h0, c, 2'h0}, {16'h0, e[15:0]});
      bus(1'b0, 8'h1C, 32'h0);
      check(32'(4'(q >> (4 * c))), 32'(e[19:16]));
    end
    rd(8'h14, {24'h0, st});
    bus(1'b1, 8'h18, 32'hFF);
    check({31'h0, irq}, {31'h0, |st});
    bus(1'b1, 8'h18, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h14, {24'h0, st});
    rd(8'h14, 32'h0);
    check(32'(n_words), 32'd151);
    stop_test();
  end
endmodule : current_input_value_coder_tb
bind civ_coder civ_checker u_chk (.ref_clk(ref_clk), .srst(srst), .sample(sample), .host_accumulator(host_accumulator),
  .irq(irq), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
